//--- design/fse_map.svh
`ifndef FSE_MAP_SVH
`define FSE_MAP_SVH

// register offsets
`define FSE_CFG_OFS          3'h4
`define FSE_ERR_CFG_OFS      3'h5
`define FSE_STAT_OFS         3'h6
`define FSE_ERR_STAT_OFS     3'h7

// command_status fields
`define FSE_COMPLETE_BIT       7
`define FSE_ACCESS_ERR_BIT     5
`define FSE_PROT_VIOL_BIT      4
`define FSE_BUSY_BIT           3
`define FSE_RSVD_BIT           2
`define FSE_COMP_STAT_HI_BIT   1
`define FSE_COMP_STAT_LO_BIT   0

// flash_config_register fields
`define FSE_IGNORE_SF_BIT      4
`define FSE_WAIT_HI_BIT        3
`define FSE_WAIT_LO_BIT        2
`define FSE_FORCE_DF_BIT       1

// ecc_error_status fields
`define FSE_DOUBLE_BIT         1
`define FSE_SINGLE_BIT         0

// error_interrupt_config fields
`define FSE_SF_IRQ_EN_BIT      0

// reset values
`define FSE_CFG_RST            8'h00
`define FSE_ERR_CFG_RST        8'h00
`define FSE_WAIT_RST           2'h0
`define FSE_COMP_STAT_RST      2'h0
`define FSE_COMP_STAT_INIT_ERR 2'h3

// wait-state encodings
`define FSE_WAIT_MAX         2'h0
`define FSE_WAIT_OFF         2'h3

`endif

//--- design/fse_pkg.sv
package fse_pkg;

   typedef enum logic [1:0] {
      FSE_IDLE   = 2'b00,
      FSE_RUN    = 2'b01
   } fse_state_t;

endpackage

//--- design/fse_status_flags.sv
// Functional notes
// R01: interrupt requested when enable and single flag
// R02: error config bits readable and writable
// R03: reserved wait codes read back, behave max
// R04: status write, read-only and zero bits
// R05: writing one launches command, clears complete
// R06: access error set on sequence violation
// R07: access error blocks launch and flag clear
// R08: access error cleared by writing one
// R09: protection flag set on protected program/erase
// R10: protection flag cleared by writing one
// R11: protection flag blocks launch and sequences
// R12: busy reads one while command executes
// R13: status bit two always reads zero
// R14: completion status set on error, cleared at start
// R15: double fault at reset may alter status
// R16: error flags readable, writes only clear
// R17: double flag on double fault or busy read
// R18: fault flags cleared by writing one
// R19: single flag set unless ignore control set
// R20: software clears flag before next fault
// R21: fault flags stored one cycle after read
// R22: ignore control suppresses single faults, interrupt
// R23: force control makes every read double fault
// R24: interrupt is enable and flag level
`timescale 1ns/100ps
`default_nettype none
`include "fse_map.svh"

module fse_status_flags (
   input  wire logic       core_clk_i,
   input  wire logic       reset_n_i,
   input  wire logic [2:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_write_i,
   input  wire logic       reg_read_i,
   output logic      [7:0] reg_rdata_o,
   input  wire logic       cmd_done_i,
   input  wire logic       cmd_seq_error_i,
   input  wire logic       cmd_prot_error_i,
   input  wire logic [1:0] cmd_completion_status_bits_i,
   input  wire logic       cmd_completion_status_bits_valid_i,
   input  wire logic       init_done_i,
   input  wire logic       init_ecc_fault_i,
   input  wire logic       array_read_i,
   input  wire logic       array_single_fault_i,
   input  wire logic       array_double_fault_i,
   input  wire logic       array_read_busy_i,
   output logic            cmd_launch_o,
   output logic            cmd_seq_allow_o,
   output logic            single_fault_irq_o,
   output logic      [1:0] wait_state_field_o,
   output logic      [1:0] wait_state_eff_o
);

   // ------------------------------------------------------------
   // register storage
   // ------------------------------------------------------------
   fse_pkg::fse_state_t state;
   // software-visible flags and configuration bits
   logic       command_complete_flag;
   logic       access_error_flag;
   logic       protection_violation_flag;
   logic [1:0] completion_status_bits;
   logic       single_fault_flag;
   logic       double_fault_flag;
   logic       single_fault_irq_enable;
   logic       ignore_single_fault;
   logic       force_double_fault;
   logic [1:0] wait_state_field;
   // ecc capture stage, one cycle behind the array read
   logic       rd_single;
   logic       rd_double;
   logic       rd_valid;

   // decoded strobes and internal conditions
   logic       wr_cfg;
   logic       wr_ecfg;
   logic       wr_stat;
   logic       wr_estat;
   logic       launch_req;
   logic       controller_busy;
   logic       cmd_end;
   logic       access_set;
   logic       access_clear;
   logic       prot_set;
   logic       prot_clear;
   logic       double_set;
   logic       double_clear;
   logic       single_set;
   logic       single_clear;
   logic [7:0] cfg_image;
   logic [7:0] err_cfg_image;
   logic [7:0] stat_image;
   logic [7:0] err_stat_image;

   // reset images, single bits are picked out of these at reset
   localparam logic [7:0] cfg_rst_image     = `FSE_CFG_RST;
   localparam logic [7:0] err_cfg_rst_image = `FSE_ERR_CFG_RST;

   assign wr_cfg   = reg_write_i && (reg_addr_i == `FSE_CFG_OFS);
   assign wr_ecfg  = reg_write_i && (reg_addr_i == `FSE_ERR_CFG_OFS);
   assign wr_stat  = reg_write_i && (reg_addr_i == `FSE_STAT_OFS);
   assign wr_estat = reg_write_i && (reg_addr_i == `FSE_ERR_STAT_OFS);

   // launch needs a finished command and no pending violation
   assign launch_req = wr_stat && reg_wdata_i[`FSE_COMPLETE_BIT] && command_complete_flag
                       && !access_error_flag && !protection_violation_flag; // R07 R11
   assign controller_busy = (state == fse_pkg::FSE_RUN); // R12
   // a running command ends on completion or on a violation seen while it runs
   assign cmd_end = controller_busy && (cmd_done_i || cmd_seq_error_i || cmd_prot_error_i); // R05

   // ------------------------------------------------------------
   // flag set and clear conditions
   // ------------------------------------------------------------
   assign access_set   = cmd_seq_error_i; // R06
   assign access_clear = wr_stat && reg_wdata_i[`FSE_ACCESS_ERR_BIT]; // R08
   assign prot_set     = cmd_prot_error_i; // R09
   assign prot_clear   = wr_stat && reg_wdata_i[`FSE_PROT_VIOL_BIT]; // R10
   assign double_set   = rd_valid && rd_double; // R17
   assign double_clear = wr_estat && reg_wdata_i[`FSE_DOUBLE_BIT]; // R18
   assign single_set   = rd_valid && rd_single && !ignore_single_fault; // R19 R22
   assign single_clear = wr_estat && reg_wdata_i[`FSE_SINGLE_BIT]; // R18

   // ------------------------------------------------------------
   // command sequencer handshake
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= fse_pkg::FSE_IDLE;
      end else begin
         case (state)
            fse_pkg::FSE_IDLE: begin
               if (launch_req) begin
                  state <= fse_pkg::FSE_RUN;
               end
            end
            fse_pkg::FSE_RUN: begin
               // a violation ends the run as completion does
               if (cmd_end) begin
                  state <= fse_pkg::FSE_IDLE;
               end
            end
            default: begin
               state <= fse_pkg::FSE_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cmd_launch_o <= 1'b0;
      end else begin
         // one pulse per accepted launch
         cmd_launch_o <= launch_req; // R05
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cmd_seq_allow_o <= 1'b0;
      end else begin
         // a new write sequence needs an idle controller and no protection violation
         cmd_seq_allow_o <= !protection_violation_flag && command_complete_flag
                            && !launch_req; // R11
      end
   end

   // ------------------------------------------------------------
   // command_status flags
   // ------------------------------------------------------------
   // complete flag low until init sequence ends
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         command_complete_flag <= 1'b0;
      end else if (!init_done_i) begin
         command_complete_flag <= 1'b0;
      end else if (launch_req) begin
         command_complete_flag <= 1'b0; // R05
      end else if (!controller_busy || cmd_end) begin
         command_complete_flag <= 1'b1; // R05
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         access_error_flag <= 1'b0;
      end else if (access_set) begin
         // set beats a same-cycle write-one clear
         access_error_flag <= 1'b1; // R06
      end else if (access_clear) begin
         access_error_flag <= 1'b0; // R08
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         protection_violation_flag <= 1'b0;
      end else if (prot_set) begin
         // set beats a same-cycle write-one clear
         protection_violation_flag <= 1'b1; // R09
      end else if (prot_clear) begin
         protection_violation_flag <= 1'b0; // R10
      end
   end

   // read-only status, loaded during init and from command errors
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         completion_status_bits <= `FSE_COMP_STAT_RST;
      end else if (!init_done_i && init_ecc_fault_i) begin
         completion_status_bits <= `FSE_COMP_STAT_INIT_ERR; // R14 R15
      end else if (cmd_completion_status_bits_valid_i) begin
         completion_status_bits <= completion_status_bits | cmd_completion_status_bits_i; // R14
      end else if (launch_req) begin
         completion_status_bits <= 2'h0; // R14
      end
   end

   // ------------------------------------------------------------
   // ecc fault capture, one cycle after the read
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rd_valid  <= 1'b0;
         rd_single <= 1'b0;
         rd_double <= 1'b0;
      end else begin
         // qualifiers are taken with the read strobe, flags follow a cycle later
         rd_valid  <= array_read_i; // R21
         rd_single <= array_single_fault_i || array_read_busy_i;
         rd_double <= array_double_fault_i || array_read_busy_i || force_double_fault; // R23
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         double_fault_flag <= 1'b0;
      end else if (double_set) begin
         // set beats a same-cycle write-one clear
         double_fault_flag <= 1'b1; // R17
      end else if (double_clear) begin
         double_fault_flag <= 1'b0; // R18 R16
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         single_fault_flag <= 1'b0;
      end else if (single_set) begin
         // set beats a same-cycle write-one clear
         single_fault_flag <= 1'b1; // R19 R22
      end else if (single_clear) begin
         single_fault_flag <= 1'b0; // R18 R16
      end
   end

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         single_fault_irq_enable <= err_cfg_rst_image[`FSE_SF_IRQ_EN_BIT];
      end else if (wr_ecfg) begin
         // only one bit of the error config register is assigned
         single_fault_irq_enable <= reg_wdata_i[`FSE_SF_IRQ_EN_BIT]; // R02
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ignore_single_fault <= cfg_rst_image[`FSE_IGNORE_SF_BIT];
         force_double_fault  <= cfg_rst_image[`FSE_FORCE_DF_BIT];
      end else if (wr_cfg) begin
         // both controls act from the next array read on
         ignore_single_fault <= reg_wdata_i[`FSE_IGNORE_SF_BIT]; // R22
         force_double_fault  <= reg_wdata_i[`FSE_FORCE_DF_BIT]; // R23
      end
   end

   // wait field holds while a command runs
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wait_state_field <= `FSE_WAIT_RST;
      end else if (wr_cfg && command_complete_flag) begin
         wait_state_field <= reg_wdata_i[`FSE_WAIT_HI_BIT:`FSE_WAIT_LO_BIT]; // R03
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wait_state_field_o <= `FSE_WAIT_RST;
         wait_state_eff_o   <= `FSE_WAIT_MAX;
      end else begin
         wait_state_field_o <= wait_state_field;
         wait_state_eff_o   <= (wait_state_field == `FSE_WAIT_OFF) ? `FSE_WAIT_OFF : `FSE_WAIT_MAX; // R03
      end
   end

   // ------------------------------------------------------------
   // register read images
   // ------------------------------------------------------------
   // configuration register image, unassigned bits read zero
   always_comb begin
      cfg_image                                    = 8'h00;
      cfg_image[`FSE_IGNORE_SF_BIT]                = ignore_single_fault;
      cfg_image[`FSE_WAIT_HI_BIT:`FSE_WAIT_LO_BIT] = wait_state_field; // R03
      cfg_image[`FSE_FORCE_DF_BIT]                 = force_double_fault;
   end

   // error configuration image
   always_comb begin
      err_cfg_image                     = 8'h00;
      err_cfg_image[`FSE_SF_IRQ_EN_BIT] = single_fault_irq_enable; // R02
   end

   // command status image, busy and completion bits are read-only
   always_comb begin
      stat_image                                              = 8'h00; // R04
      stat_image[`FSE_COMPLETE_BIT]                           = command_complete_flag;
      stat_image[`FSE_ACCESS_ERR_BIT]                         = access_error_flag;
      stat_image[`FSE_PROT_VIOL_BIT]                          = protection_violation_flag;
      stat_image[`FSE_BUSY_BIT]                               = controller_busy; // R12
      stat_image[`FSE_RSVD_BIT]                               = 1'b0; // R13
      stat_image[`FSE_COMP_STAT_HI_BIT:`FSE_COMP_STAT_LO_BIT] = completion_status_bits; // R14
   end

   // ecc status image
   always_comb begin
      err_stat_image                  = 8'h00;
      err_stat_image[`FSE_DOUBLE_BIT] = double_fault_flag; // R16
      err_stat_image[`FSE_SINGLE_BIT] = single_fault_flag; // R16
   end

   // ------------------------------------------------------------
   // interrupt and read data
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         single_fault_irq_o <= 1'b0;
      end else begin
         single_fault_irq_o <= single_fault_irq_enable && single_fault_flag; // R01 R24
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_read_i) begin
         case (reg_addr_i)
            `FSE_CFG_OFS: begin
               reg_rdata_o <= cfg_image;
            end
            `FSE_ERR_CFG_OFS: begin
               reg_rdata_o <= err_cfg_image; // R02
            end
            `FSE_STAT_OFS: begin
               reg_rdata_o <= stat_image; // R04 R12 R13
            end
            `FSE_ERR_STAT_OFS: begin
               reg_rdata_o <= err_stat_image; // R16
            end
            default: begin
               reg_rdata_o <= 8'h00;
            end
         endcase
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

endmodule

`default_nettype wire

//--- testbench/fse_status_flags_properties.sv
`timescale 1ns/100ps
`default_nettype none
module fse_status_flags_chk (
   input  wire logic       core_clk_i,
   input  wire logic       reset_n_i,
   input  wire logic [2:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_write_i,
   input  wire logic       reg_read_i,
   input  wire logic [7:0] reg_rdata_o,
   input  wire logic       array_read_i,
   input  wire logic       cmd_launch_o,
   input  wire logic       single_fault_irq_o,
   input  wire logic [1:0] wait_state_field_o,
   input  wire logic [1:0] wait_state_eff_o
);
   // ----
   // assertions
   // ----
   default clocking @(posedge core_clk_i);
   endclocking
   default disable iff (!reset_n_i);
   property p_launch_pulse;
      cmd_launch_o |=> !cmd_launch_o;
   endproperty
   a_launch_pulse: assert property (p_launch_pulse) else $error("launch too long");
   property p_launch_cause;
      cmd_launch_o |-> $past(reg_write_i && reg_addr_i == 3'h6 && reg_wdata_i[7]);
   endproperty
   a_launch_cause: assert property (p_launch_cause) else $error("launch without write");
   property p_stat_rsvd;
      $past(reg_read_i && reg_addr_i == 3'h6) |-> !reg_rdata_o[6] && !reg_rdata_o[2];
   endproperty
   a_stat_rsvd: assert property (p_stat_rsvd) else $error("reserved status bit set");
   property p_busy_command_complete_flag;
      $past(reg_read_i && reg_addr_i == 3'h6) && reg_rdata_o[3] |-> !reg_rdata_o[7];
   endproperty
   a_busy_command_complete_flag: assert property (p_busy_command_complete_flag) else $error("busy with complete set");
   property p_ecc_upper;
      $past(reg_read_i && reg_addr_i == 3'h7) |-> reg_rdata_o[7:2] == 6'h00;
   endproperty
   a_ecc_upper: assert property (p_ecc_upper) else $error("ecc status upper bits set");
   property p_wait_eff;
      $stable(wait_state_field_o) ##1 $stable(wait_state_field_o)
         |-> wait_state_eff_o == ((wait_state_field_o == 2'h3) ? 2'h3 : 2'h0);
   endproperty
   a_wait_eff: assert property (p_wait_eff) else $error("effective wait wrong");
   property p_irq_clear;
      reg_write_i && reg_addr_i == 3'h7 && reg_wdata_i[0] && !$past(array_read_i) |-> ##2 !single_fault_irq_o;
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("irq after clear");
   property p_irq_rise;
      $rose(single_fault_irq_o) |-> $past(array_read_i, 3) || $past(reg_write_i && reg_addr_i == 3'h5, 2);
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("irq without cause");
   c_launch: cover property (cmd_launch_o);
   c_irq: cover property (single_fault_irq_o);
   c_done: cover property ($past(reg_read_i && reg_addr_i == 3'h6) && reg_rdata_o[7]);
endmodule
bind fse_status_flags fse_status_flags_chk i_chk (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
   .reg_rdata_o(reg_rdata_o), .array_read_i(array_read_i), .cmd_launch_o(cmd_launch_o),
   .single_fault_irq_o(single_fault_irq_o), .wait_state_field_o(wait_state_field_o),
   .wait_state_eff_o(wait_state_eff_o));
`default_nettype wire

//--- testbench/tb_fse_status_flags.sv
`timescale 1ns/100ps
`default_nettype none
module tb_fse_status_flags;
   typedef struct {logic [2:0] a; logic [7:0] d; logic [7:0] r; logic [1:0] e; logic [1:0] f;} fse_row_t;
   logic       clk;
   logic       rst_n;
   logic [2:0] addr;
   logic [7:0] wd;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic [7:0] pv;
   logic [1:0] mg;
   logic       init_done;
   logic       init_fault;
   logic       launch;
   logic       allow;
   logic       irq;
   logic [1:0] weff;
   logic [1:0] wfield;
   int         mismatches;
   int         total_checks;
   fse_row_t   rows[7];
   fse_status_flags i_dut (.core_clk_i(clk), .reset_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wd),
      .reg_write_i(wr), .reg_read_i(rd), .reg_rdata_o(rdata), .cmd_done_i(pv[0]), .cmd_seq_error_i(pv[1]),
      .cmd_prot_error_i(pv[2]), .cmd_completion_status_bits_i(mg), .cmd_completion_status_bits_valid_i(pv[3]), .init_done_i(init_done),
      .init_ecc_fault_i(init_fault), .array_read_i(pv[4]), .array_single_fault_i(pv[5]),
      .array_double_fault_i(pv[6]), .array_read_busy_i(pv[7]), .cmd_launch_o(launch),
      .cmd_seq_allow_o(allow), .single_fault_irq_o(irq), .wait_state_field_o(wfield), .wait_state_eff_o(weff));
   // ----
   // tasks
   // ----
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk8(rdata, e);
   endtask
   task automatic pulse(input logic [7:0] v);
      @(posedge clk);
      pv <= v;
      @(posedge clk);
      pv <= 8'h00;
   endtask
   task automatic report_and_stop;
      if (mismatches == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      #100000;
      mismatches++;
      report_and_stop();
   end
   // ----
   // sequence
   // ----
   initial begin
      rst_n = 1'b0;
      addr = 3'h0;
      wd = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      pv = 8'h00;
      mg = 2'h0;
      init_done = 1'b0;
      init_fault = 1'b1;
      rows = '{'{3'h4, 8'h0c, 8'h0c, 2'h3, 2'h3}, '{3'h4, 8'h04, 8'h04, 2'h0, 2'h1},
               '{3'h4, 8'h08, 8'h08, 2'h0, 2'h2}, '{3'h5, 8'h01, 8'h01, 2'h0, 2'h2},
               '{3'h5, 8'h00, 8'h00, 2'h0, 2'h2}, '{3'h0, 8'hff, 8'h00, 2'h0, 2'h2},
               '{3'h4, 8'h00, 8'h00, 2'h0, 2'h0}};
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rreg(3'h6, 8'h03);
      @(posedge clk);
      init_fault <= 1'b0;
      init_done <= 1'b1;
      mg <= 2'h1;
      repeat (2) @(posedge clk);
      rreg(3'h6, 8'h83);
      foreach (rows[i]) begin
         wreg(rows[i].a, rows[i].d);
         rreg(rows[i].a, rows[i].r);
         chk8({6'h00, weff}, {6'h00, rows[i].e});
         chk8({6'h00, wfield}, {6'h00, rows[i].f});
      end
      wreg(3'h6, 8'h80);
      #1;
      chk8({7'h00, launch}, 8'h01);
      rreg(3'h6, 8'h08);
      wreg(3'h4, 8'h0c);
      rreg(3'h4, 8'h00);
      chk8({6'h00, wfield}, 8'h00);
      pulse(8'h09);
      rreg(3'h6, 8'h81);
      pulse(8'h02);
      rreg(3'h6, 8'ha1);
      wreg(3'h6, 8'h80);
      #1;
      chk8({7'h00, launch}, 8'h00);
      wreg(3'h6, 8'h00);
      rreg(3'h6, 8'ha1);
      wreg(3'h6, 8'h20);
      rreg(3'h6, 8'h81);
      pulse(8'h04);
      rreg(3'h6, 8'h91);
      chk8({7'h00, allow}, 8'h00);
      wreg(3'h6, 8'h80);
      #1;
      chk8({7'h00, launch}, 8'h00);
      wreg(3'h6, 8'h10);
      rreg(3'h6, 8'h81);
      chk8({7'h00, allow}, 8'h01);
      wreg(3'h6, 8'h80);
      pulse(8'h02);
      rreg(3'h6, 8'ha0);
      wreg(3'h6, 8'h20);
      wreg(3'h5, 8'h01);
      pulse(8'h30);
      repeat (2) @(posedge clk);
      #1;
      chk8({7'h00, irq}, 8'h01);
      rreg(3'h7, 8'h01);
      wreg(3'h7, 8'h02);
      rreg(3'h7, 8'h01);
      wreg(3'h7, 8'h01);
      rreg(3'h7, 8'h00);
      chk8({7'h00, irq}, 8'h00);
      pulse(8'h50);
      rreg(3'h7, 8'h02);
      pulse(8'h90);
      rreg(3'h7, 8'h03);
      wreg(3'h7, 8'hff);
      rreg(3'h7, 8'h00);
      wreg(3'h4, 8'h10);
      pulse(8'h30);
      rreg(3'h7, 8'h00);
      chk8({7'h00, irq}, 8'h00);
      wreg(3'h4, 8'h02);
      pulse(8'h10);
      rreg(3'h7, 8'h02);
      report_and_stop();
   end
endmodule
`default_nettype wire
